// >>> verilog/dmr_regs.sv
// mode, interface, scratch memory window and broadcast code register bank
// What this block does
// - protect code 00: hi-z, no slew
// - protect code 01: load stored code, hi-z
// - protect code 10: slew margin-low, then hi-z
// - protect code 11: slew margin-high, then hi-z
// - pmbus accepted only when bit eight set
// - bit two picks fast readout timing
// - bit zero routes serial output to pin
// - pointer field selects next memory location
// - pointer increments after each window write
// - window moves full word at pointer
// - broadcast code bits 15-4 drive channels
// - protect starts on falling pin edge only
`timescale 1ns/10ps
module dmr_regs #(
  parameter int CODE_BITS = 12,
  parameter int NCH       = 2
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  // register access from the serial front end
  input  wire dmr_pkg::dmr_req_s             req,
  output logic      [15:0]                   rdata,
  // channel context
  input  wire logic [NCH-1:0]                channel_broadcast_enable,
  input  wire logic [3:0]                    pin_input_function,
  input  wire logic                          gpio_in,
  input  wire logic [11:0]                   nvm_code,
  input  wire logic [11:0]                   margin_low_code,
  input  wire logic [11:0]                   margin_high_code,
  input  wire logic                          slew_done,
  // serial front end controls
  input  wire logic                          serial_out,
  output logic                               low_power_select,
  output logic                               bus_timeout_enable,
  output logic                               pmbus_enable,
  output logic                               fast_readout_enable,
  output logic                               readout_pin_enable,
  output logic                               gpio_out,
  output logic                               gpio_oe,
  // channel outputs
  output dmr_pkg::dmr_chan_cmd_s             prot_cmd,
  output logic      [NCH-1:0]                bcast_load,
  output logic      [CODE_BITS-1:0]          broadcast_code
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [15:0] mode_q;     // device mode config
  logic [15:0] iface_q;    // interface config
  logic [7:0]  ptr_q;      // scratch pointer
  logic [15:0] bcast_q;    // broadcast code word
  logic [15:0] mem_rdata;  // word at pointer
  logic        win_wr;     // window write this cycle
  logic        gpio_q;     // last pin level
  logic        prot_fall;  // qualified falling edge
  dmr_pkg::dmr_prot_e st_q;
  dmr_pkg::dmr_prot_e st_d;
  logic [1:0]  resp_q;     // response latched at trigger

  // window write strobe
  assign win_wr = req.wr && (req.addr == dmr_pkg::ADDR_SCRATCH_MEM_DATA);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // masks drop don't care bits so they store nothing
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_q  <= dmr_pkg::RST_WORD;
      iface_q <= dmr_pkg::RST_WORD;
      bcast_q <= dmr_pkg::RST_WORD;
    end
    else if (req.wr)
    begin
      case (req.addr)
        dmr_pkg::ADDR_DEVICE_MODE_CONFIG:
          mode_q  <= req.wdata & dmr_pkg::MASK_MODE;
        dmr_pkg::ADDR_INTERFACE_CONFIG:
          iface_q <= req.wdata & dmr_pkg::MASK_IFACE;
        dmr_pkg::ADDR_BROADCAST_CODE:
          bcast_q <= req.wdata & dmr_pkg::MASK_BCAST;
        default:
          ;
      endcase
    end
  end

  // ----------------------------------------
  // scratch pointer
  // ----------------------------------------
  // explicit pointer write wins; otherwise window write advances it
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ptr_q <= '0;
    else if (req.wr && req.addr == dmr_pkg::ADDR_SCRATCH_MEM_POINTER)
      ptr_q <= req.wdata[7:0];
    else if (win_wr)
      ptr_q <= ptr_q + 8'h01;
  end

  // scratch storage, full word at pointer
  dmr_scratch_mem #(
    .DEPTH (256),
    .WIDTH (16)
  ) u_mem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .we      (win_wr),
    .waddr   (ptr_q),
    .wdata   (req.wdata),
    .raddr   (ptr_q),
    .rdata   (mem_rdata)
  );

  // ----------------------------------------
  // read mux, registered data
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata <= '0;
    else if (req.rd)
    begin
      case (req.addr)
        dmr_pkg::ADDR_DEVICE_MODE_CONFIG:  rdata <= mode_q;
        dmr_pkg::ADDR_INTERFACE_CONFIG:    rdata <= iface_q;
        dmr_pkg::ADDR_SCRATCH_MEM_POINTER: rdata <= {8'h00, ptr_q};
        dmr_pkg::ADDR_SCRATCH_MEM_DATA:    rdata <= mem_rdata;
        dmr_pkg::ADDR_BROADCAST_CODE:      rdata <= bcast_q;
        default:                           rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // interface controls
  // ----------------------------------------
  assign low_power_select    = mode_q[dmr_pkg::POS_LOW_POWER];
  assign bus_timeout_enable  = iface_q[dmr_pkg::POS_TIMEOUT_EN];
  assign pmbus_enable        = iface_q[dmr_pkg::POS_PMBUS_EN];
  assign fast_readout_enable = iface_q[dmr_pkg::POS_FAST_RD];
  assign readout_pin_enable  = iface_q[dmr_pkg::POS_RD_PIN];
  // pin left undriven unless readout routed there
  assign gpio_out = serial_out & readout_pin_enable;
  assign gpio_oe  = readout_pin_enable;

  // ----------------------------------------
  // broadcast code
  // ----------------------------------------
  // left aligned: a narrow variant takes the top bits and drops the rest
  assign broadcast_code = bcast_q[15 -: CODE_BITS];
  // one load pulse per enabled channel on each code write
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      bcast_load <= '0;
    else if (req.wr && req.addr == dmr_pkg::ADDR_BROADCAST_CODE)
      bcast_load <= channel_broadcast_enable;
    else
      bcast_load <= '0;
  end

  // ----------------------------------------
  // protect trigger, falling edge of pin
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      gpio_q <= 1'b1;
    else
      gpio_q <= gpio_in;
  end

  // high level does nothing; only a high to low step counts
  assign prot_fall = gpio_q && !gpio_in
                     && (pin_input_function == dmr_pkg::PIN_FUNC_PROTECT);

  // ----------------------------------------
  // protect sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q   <= dmr_pkg::PS_IDLE;
      resp_q <= dmr_pkg::PROT_HIZ;
    end
    else
    begin
      st_q <= st_d;
      if (prot_fall && st_q == dmr_pkg::PS_IDLE)
        resp_q <= mode_q[dmr_pkg::POS_PROTECT_LO +: 2];
    end
  end

  // next state from the response field
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      dmr_pkg::PS_IDLE:
        if (prot_fall)
        begin
          case (mode_q[dmr_pkg::POS_PROTECT_LO +: 2])
            dmr_pkg::PROT_HIZ:      st_d = dmr_pkg::PS_PDOWN;
            dmr_pkg::PROT_NVM_CODE: st_d = dmr_pkg::PS_LOAD;
            default:                st_d = dmr_pkg::PS_SLEW;
          endcase
        end
      dmr_pkg::PS_LOAD:  st_d = dmr_pkg::PS_PDOWN;
      dmr_pkg::PS_SLEW:  if (slew_done) st_d = dmr_pkg::PS_PDOWN;
      // power-down holds until a reset of the device
      dmr_pkg::PS_PDOWN: st_d = dmr_pkg::PS_PDOWN;
      default:           st_d = dmr_pkg::PS_IDLE;
    endcase
  end

  // ----------------------------------------
  // protect command outputs
  // ----------------------------------------
  always_comb
  begin
    prot_cmd.load = (st_q == dmr_pkg::PS_LOAD);
    prot_cmd.slew = (st_q == dmr_pkg::PS_SLEW);
    prot_cmd.hiz  = (st_q == dmr_pkg::PS_PDOWN);
    case (resp_q)
      dmr_pkg::PROT_NVM_CODE:  prot_cmd.code = nvm_code;
      dmr_pkg::PROT_MARGIN_LO: prot_cmd.code = margin_low_code;
      dmr_pkg::PROT_MARGIN_HI: prot_cmd.code = margin_high_code;
      default:                 prot_cmd.code = '0;
    endcase
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_PTR_INC: assert property (@(posedge clk_sys) disable iff (!resetn)
    win_wr |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance after window write");
  AST_HIZ_DIRECT: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q == dmr_pkg::PS_IDLE && prot_fall && mode_q[9:8] == 2'h0) |=> prot_cmd.hiz)
    else $error("protect code zero did not power down at once");
  AST_NVM_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q == dmr_pkg::PS_IDLE && prot_fall && mode_q[9:8] == 2'h1)
      |=> prot_cmd.load && prot_cmd.code == nvm_code ##1 prot_cmd.hiz)
    else $error("stored code load sequence wrong");
  AST_SLEW_LO: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q == dmr_pkg::PS_IDLE && prot_fall && mode_q[9:8] == 2'h2)
      |=> prot_cmd.slew && prot_cmd.code == margin_low_code)
    else $error("margin-low slew not started");
  AST_SLEW_HI: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q == dmr_pkg::PS_IDLE && prot_fall && mode_q[9:8] == 2'h3)
      |=> prot_cmd.slew && prot_cmd.code == margin_high_code)
    else $error("margin-high slew not started");
  AST_NO_LEVEL: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q == dmr_pkg::PS_IDLE && !prot_fall) |=> st_q == dmr_pkg::PS_IDLE)
    else $error("protect started without falling edge");
  AST_PIN_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    !iface_q[0] |-> !gpio_oe && !gpio_out)
    else $error("readout pin driven while disabled");
  AST_PMBUS: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.wr && req.addr == dmr_pkg::ADDR_INTERFACE_CONFIG) |=> pmbus_enable == $past(req.wdata[8]))
    else $error("pmbus enable not following bit eight");
  AST_TIMEOUT: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.wr && req.addr == dmr_pkg::ADDR_INTERFACE_CONFIG)
      |=> bus_timeout_enable == $past(req.wdata[12]))
    else $error("timeout enable not following bit twelve");
  AST_FAST: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.wr && req.addr == dmr_pkg::ADDR_INTERFACE_CONFIG)
      |=> fast_readout_enable == $past(req.wdata[2]))
    else $error("fast readout not following bit two");
  AST_DONT_CARE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.addr == dmr_pkg::ADDR_BROADCAST_CODE) |=> rdata[3:0] == 4'h0)
    else $error("don't care bits read nonzero");
  AST_BCAST: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.wr && req.addr == dmr_pkg::ADDR_BROADCAST_CODE)
      |=> bcast_load == $past(channel_broadcast_enable)
          && broadcast_code == $past(req.wdata[15 -: CODE_BITS]))
    else $error("broadcast code not applied");

endmodule

// >>> verilog/dmr_pkg.sv
// shared constants and carrier types for the mode, interface and scratch memory registers
package dmr_pkg;

  // ----------------------------------------
  // register addresses (8-bit register pointer)
  // ----------------------------------------
  localparam logic [7:0] ADDR_DEVICE_MODE_CONFIG  = 8'h25;
  localparam logic [7:0] ADDR_INTERFACE_CONFIG    = 8'h26;
  localparam logic [7:0] ADDR_SCRATCH_MEM_POINTER = 8'h2B;
  localparam logic [7:0] ADDR_SCRATCH_MEM_DATA    = 8'h2C;
  localparam logic [7:0] ADDR_BROADCAST_CODE      = 8'h50;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------
  // field positions and writable masks
  // ----------------------------------------
  localparam int          POS_LOW_POWER   = 13;
  localparam int          POS_PROTECT_LO  = 8;
  localparam int          POS_TIMEOUT_EN  = 12;
  localparam int          POS_PMBUS_EN    = 8;
  localparam int          POS_FAST_RD     = 2;
  localparam int          POS_RD_PIN      = 0;
  localparam int          POS_BCAST_LO    = 4;
  localparam logic [15:0] MASK_MODE       = 16'hE3E0; // 4-0 don't care read zero
  localparam logic [15:0] MASK_IFACE      = 16'h1105;
  localparam logic [15:0] MASK_POINTER    = 16'h00FF;
  localparam logic [15:0] MASK_BCAST      = 16'hFFF0;

  // ----------------------------------------
  // protect response encodings
  // ----------------------------------------
  localparam logic [1:0] PROT_HIZ       = 2'h0;
  localparam logic [1:0] PROT_NVM_CODE  = 2'h1;
  localparam logic [1:0] PROT_MARGIN_LO = 2'h2;
  localparam logic [1:0] PROT_MARGIN_HI = 2'h3;

  // pin input function code that arms the protect input
  localparam logic [3:0] PIN_FUNC_PROTECT = 4'h5;

  // ----------------------------------------
  // protect sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0]
  {
    PS_IDLE  = 4'b0001,
    PS_LOAD  = 4'b0010,
    PS_SLEW  = 4'b0100,
    PS_PDOWN = 4'b1000
  } dmr_prot_e;

  // ----------------------------------------
  // register access request carrier
  // ----------------------------------------
  typedef struct packed
  {
    logic        wr;    // write strobe
    logic        rd;    // read strobe
    logic [7:0]  addr;  // register address
    logic [15:0] wdata; // write word
  } dmr_req_s;

  // per-channel output command carrier
  typedef struct packed
  {
    logic        load;  // load code now, no slew
    logic        slew;  // slew toward code
    logic        hiz;   // high-impedance power-down
    logic [11:0] code;  // target code
  } dmr_chan_cmd_s;

endpackage

// >>> verilog/dmr_scratch_mem.sv
// scratch memory: word storage in flip-flops with one write and one read port
`timescale 1ns/10ps
module dmr_scratch_mem #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // read port, combinational
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  // storage array, cleared at reset
  logic [WIDTH-1:0] mem_q [DEPTH];

  // ----------------------------------------
  // write process
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  // read is a plain index
  assign rdata = mem_q[raddr];

endmodule

// >>> dv/dmr_host_model.sv
// host controller model issuing register requests to the register bank
`timescale 1ns/10ps
module dmr_host_model (
  // clock
  input  wire logic         clk_sys,
  // register requests and answers
  output dmr_pkg::dmr_req_s req,
  input  wire logic [15:0]  rdata
);
  // ----------------------------------------
  // request tasks
  // ----------------------------------------
  // idle bus at time zero
  initial req = '0;

  // one write, held for exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    // released fields show inverted leftovers, so stale values cannot pass
    req <= {1'b0, 1'b0, ~a, ~d};
  endtask

  // one read; the word is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    req <= {1'b0, 1'b0, ~a, 16'hFFFF};
    #1 d = rdata;
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the mode, interface, scratch memory and broadcast registers
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  typedef struct packed
  {
    logic [7:0]  a; // address
    logic [15:0] d; // word written
    logic [15:0] e; // word read back
  } dmr_row_s;
  dmr_row_s               rows [7]; // table rows, filled at time zero
  logic                   clk_sys;
  logic                   resetn;
  dmr_pkg::dmr_req_s      req;
  logic [15:0]            rdata;
  logic [1:0]             channel_broadcast_enable;
  logic [3:0]             pin_input_function;
  logic                   gpio_in;
  logic                   slew_done;
  logic                   serial_out;
  logic                   low_power_select;
  logic                   bus_timeout_enable;
  logic                   pmbus_enable;
  logic                   fast_readout_enable;
  logic                   readout_pin_enable;
  logic                   gpio_out;
  logic                   gpio_oe;
  dmr_pkg::dmr_chan_cmd_s prot_cmd;
  logic [1:0]             bcast_load;
  logic [11:0]            broadcast_code;
  logic [15:0]            rd_word;  // last word read
  logic [1:0]             bl_seen;  // channels that saw a load pulse
  logic                   seen_load; // protect load observed
  logic                   seen_slew; // protect slew observed
  logic [11:0]            got_code; // code seen with load or slew
  int                     errors;
  int                     cmp_count;

  // ----------------------------------------
  // design and host model
  // ----------------------------------------
  dmr_regs #(.CODE_BITS(12), .NCH(2)) u_dmr_regs (
    .clk_sys(clk_sys), .resetn(resetn), .req(req), .rdata(rdata),
    .channel_broadcast_enable(channel_broadcast_enable),
    .pin_input_function(pin_input_function), .gpio_in(gpio_in),
    .nvm_code(12'h0A5), .margin_low_code(12'h123), .margin_high_code(12'hEDC),
    .slew_done(slew_done), .serial_out(serial_out),
    .low_power_select(low_power_select), .bus_timeout_enable(bus_timeout_enable),
    .pmbus_enable(pmbus_enable), .fast_readout_enable(fast_readout_enable),
    .readout_pin_enable(readout_pin_enable), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .prot_cmd(prot_cmd), .bcast_load(bcast_load), .broadcast_code(broadcast_code));
  dmr_host_model u_dmr_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata));

  // ----------------------------------------
  // clock, monitors, helpers
  // ----------------------------------------
  // 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // short pulses are caught here, not by polling
  // cleared here during reset, so no clear races the capture at the release edge
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      {bl_seen, seen_load, seen_slew, got_code} <= '0;
    end
    else
    begin
      bl_seen <= bl_seen | bcast_load;
      if (prot_cmd.load || prot_cmd.slew)
      begin
        got_code <= prot_cmd.code;
      end
      seen_load <= seen_load | prot_cmd.load;
      seen_slew <= seen_slew | prot_cmd.slew;
    end
  end

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // reset for 16 cycles, monitors cleared
  task automatic rst();
    resetn <= 1'b0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask

  // verdict, the single end of the run
  task automatic tally_and_finish();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #500000;
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    errors = 0;
    cmp_count = 0;
    {channel_broadcast_enable, slew_done, serial_out} = '0;
    pin_input_function = 4'h0;
    gpio_in = 1'b1;
    // address, word written, word read back
    rows[0] = {8'h25, 16'h231F, 16'h2300};
    rows[1] = {8'h26, 16'hFFFF, 16'h1105};
    rows[2] = {8'h26, 16'h0000, 16'h0000};
    rows[3] = {8'h2B, 16'hFFFF, 16'h00FF};
    rows[4] = {8'h50, 16'hFFFF, 16'hFFF0};
    rows[5] = {8'h50, 16'hABC5, 16'hABC0};
    rows[6] = {8'h77, 16'hFFFF, 16'h0000};
    rst();
    // every table address reads zero after reset; the scratch data window is not read
    foreach (rows[i])
    begin
      u_dmr_host_model.rd(rows[i].a, rd_word);
      chk(rd_word, 16'h0000);
    end
    // table of writes and readbacks
    foreach (rows[i])
    begin
      u_dmr_host_model.wr(rows[i].a, rows[i].d);
      u_dmr_host_model.rd(rows[i].a, rd_word);
      chk(rd_word, rows[i].e);
    end
    chk({15'h0, low_power_select}, 16'h0001);
    // interface controls and readout pin
    @(posedge clk_sys) serial_out <= 1'b1;
    u_dmr_host_model.wr(dmr_pkg::ADDR_INTERFACE_CONFIG, 16'h1105);
    @(posedge clk_sys);
    #1 chk({bus_timeout_enable, pmbus_enable, fast_readout_enable, readout_pin_enable,
            gpio_oe, gpio_out}, 16'h003F);
    u_dmr_host_model.wr(dmr_pkg::ADDR_INTERFACE_CONFIG, 16'h0000);
    @(posedge clk_sys);
    #1 chk({bus_timeout_enable, pmbus_enable, fast_readout_enable, readout_pin_enable,
            gpio_oe, gpio_out}, 16'h0000);
    // window writes across the pointer wrap
    u_dmr_host_model.wr(dmr_pkg::ADDR_SCRATCH_MEM_POINTER, 16'h00FE);
    u_dmr_host_model.wr(dmr_pkg::ADDR_SCRATCH_MEM_DATA, 16'h1111);
    u_dmr_host_model.wr(dmr_pkg::ADDR_SCRATCH_MEM_DATA, 16'h2222);
    u_dmr_host_model.wr(dmr_pkg::ADDR_SCRATCH_MEM_DATA, 16'h3333);
    u_dmr_host_model.rd(dmr_pkg::ADDR_SCRATCH_MEM_POINTER, rd_word);
    chk(rd_word, 16'h0001);
    u_dmr_host_model.wr(dmr_pkg::ADDR_SCRATCH_MEM_POINTER, 16'h00FF);
    repeat (2)
    begin
      // reads leave the pointer alone
      u_dmr_host_model.rd(dmr_pkg::ADDR_SCRATCH_MEM_DATA, rd_word);
      chk(rd_word, 16'h2222);
    end
    u_dmr_host_model.wr(dmr_pkg::ADDR_SCRATCH_MEM_POINTER, 16'h0000);
    u_dmr_host_model.rd(dmr_pkg::ADDR_SCRATCH_MEM_DATA, rd_word);
    chk(rd_word, 16'h3333);
    // broadcast reaches only the enabled channel
    bl_seen = 2'b00;
    @(posedge clk_sys) channel_broadcast_enable <= 2'b10;
    u_dmr_host_model.wr(dmr_pkg::ADDR_BROADCAST_CODE, 16'h5A5C);
    repeat (3) @(posedge clk_sys);
    #1 chk({2'b00, bl_seen, broadcast_code}, 16'h25A5);
    // each protect response, one per reset
    for (int c = 0; c < 4; c++)
    begin
      // pin back to idle high first: a pin left low would look like a fall after reset
      @(posedge clk_sys);
      gpio_in            <= 1'b1;
      pin_input_function <= 4'h0;
      rst();
      u_dmr_host_model.wr(dmr_pkg::ADDR_DEVICE_MODE_CONFIG, {6'h00, c[1:0], 8'h00});
      pin_input_function <= 4'h2;
      gpio_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
      gpio_in <= 1'b1;
      pin_input_function <= dmr_pkg::PIN_FUNC_PROTECT;
      repeat (4) @(posedge clk_sys);
      #1 chk({15'h0, prot_cmd.hiz}, 16'h0000);
      @(posedge clk_sys) gpio_in <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 chk({15'h0, prot_cmd.hiz}, {15'h0, ~c[1]});
      @(posedge clk_sys) slew_done <= 1'b1;
      repeat (3) @(posedge clk_sys);
      slew_done <= 1'b0;
      #1 chk({1'b0, seen_load, seen_slew, prot_cmd.hiz, got_code},
             c == 0 ? 16'h1000 : c == 1 ? 16'h50A5 :
             c == 2 ? 16'h3123 : 16'h3EDC);
    end
    tally_and_finish();
  end
endmodule
